// *** logic/mcc_pkg.sv ***
// package: constants of the heat/cooling calculator
package mcc_pkg;
   localparam int AW = 8;
   localparam int TW = 16;
   localparam int VW = 16;
   localparam int DTW = 33;
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_OFS = 8'h04;
   localparam logic [7:0] A_HCL = 8'h08;
   localparam logic [7:0] A_AVG = 8'h0c;
   localparam logic [7:0] A_HEAT = 8'h10;
   localparam logic [7:0] A_COOL = 8'h14;
   localparam logic [7:0] A_SEL = 8'h18;
   localparam logic [7:0] A_RVAL = 8'h1c;
   localparam logic [7:0] A_RDATE = 8'h20;
   localparam logic [7:0] A_RTIME = 8'h24;
   localparam int CFG_OFSEN = 4;
   localparam logic [3:0] T_HEAT = 4'h2;
   localparam logic [3:0] T_BIF = 4'h3;
   localparam logic [3:0] T_COOL = 4'h5;
   localparam logic [3:0] T_LIM = 4'h6;
   localparam logic [3:0] TYPE_RST = T_HEAT;
   localparam logic OFSEN_RST = 1'b1;
   localparam int OFS_LIM = 32'sh63;
   localparam logic [15:0] HCL_MIN = 16'h0001;
   localparam logic [15:0] HCL_MAX = 16'h4650;
   localparam logic [15:0] HCL_OFF = 16'h61a8;
   localparam logic [10:0] AVG_MIN = 11'h001;
   localparam logic [10:0] AVG_MAX = 11'h5a0;
   localparam logic [10:0] AVG_RST = 11'h03c;
   localparam logic [31:0] OFF_READ = 32'h8000_0000;
   localparam logic [15:0] CENTURY = 16'h07d0;
   localparam int SEL_MX = 0;
   localparam int SEL_YR = 1;
   localparam int SEL_QTY = 2;
   localparam int SEL_LOG = 3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV = 2'b01,
      ST_CMP = 2'b10
   } mcc_state_t;
endpackage : mcc_pkg

// *** logic/mcc_calc.sv ***
// top: offset correction, heat/cooling split, sliding min/max records
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - one offset corrects inlet, outlet and aux temperatures alike
// - offset accepted only within -0.99..+0.99 K, 0.01 K steps
// - offset is added to the measured temperature
// - zero offset leaves temperatures unchanged
// - offset disabled: reads show off, no offset applied
// - meter type 2 heat, 5 cooling, 3 and 6 bifunctional
// - bifunctional: heat when inlet above outlet, cooling when below
// - limit on: heat needs inlet at least limit, cooling inlet below
// - limit settable only in type 6, 0.01..180.00 C
// - limit value 250.00 C means limit disabled
// - other meter types hold the limit disabled always
// - no hysteresis: decision redone on every calculation
// - min and max of flow and power, per month and per year
// - keep two yearly and twelve monthly historic records
// - record date as four-digit year, plus serial time stamp
// - candidate is mean of all values in the averaging period
// - larger mean replaces max, smaller replaces min, with date
// - averaging period 1..1440 minutes in one-minute steps
// - averaging period defaults to 60 minutes, changeable later
// - sliding window back from now, not calendar aligned
// - min or max indicator lit, log indicator for history
// - frame year digits for yearly, month digits for monthly
module mcc_calc #(
   parameter int WIN_MAX = 1440,
   parameter int MLOG = 12,
   parameter int YLOG = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mcc_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic temp_valid,
   input wire logic signed [mcc_pkg::TW-1:0] inlet_temp,
   input wire logic signed [mcc_pkg::TW-1:0] outlet_temp,
   input wire logic signed [mcc_pkg::TW-1:0] aux_temp,
   output logic corr_valid,
   output logic signed [mcc_pkg::TW-1:0] inlet_corr,
   output logic signed [mcc_pkg::TW-1:0] outlet_corr,
   output logic signed [mcc_pkg::TW-1:0] aux_corr,
   input wire logic calc_strobe,
   input wire logic [15:0] energy_incr,
   output logic heat_active,
   output logic cool_active,
   output logic [31:0] heat_energy_acc,
   output logic [31:0] cooling_energy_acc,
   input wire logic sample_valid,
   input wire logic [mcc_pkg::VW-1:0] flow_val,
   input wire logic [mcc_pkg::VW-1:0] power_val,
   input wire logic minute_tick,
   input wire logic month_roll,
   input wire logic year_roll,
   input wire logic [15:0] rtc_date,
   input wire logic [16:0] rtc_time,
   output logic offset_off,
   output logic ind_min,
   output logic ind_max,
   output logic ind_log,
   output logic frame_year,
   output logic frame_month
);
   import mcc_pkg::*;

   if (WIN_MAX < int'(AVG_MAX) || WIN_MAX > 2047 || MLOG < 1 || MLOG > 16 ||
       YLOG < 1 || YLOG > 16) begin : g_bad
      $error("mcc_calc: unsupported parameters");
   end

   logic [3:0] mtype;
   logic ofs_en;
   logic signed [7:0] ofs;
   logic [15:0] hcl;
   logic [10:0] avg_per;
   logic [10:0] per_q;
   logic [7:0] rec_sel;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_en;
   logic type_ok;
   logic [15:0] ofs_ext;

   // apb slave: one wait-free access cycle
   assign wr_en = psel & penable & pready & pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         prdata <= rd_data;
         pslverr <= !rd_hit;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   assign type_ok = pwdata[3:0] == T_HEAT || pwdata[3:0] == T_BIF ||
                    pwdata[3:0] == T_COOL || pwdata[3:0] == T_LIM;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mtype <= TYPE_RST;
         ofs_en <= OFSEN_RST;
         ofs <= '0;
         hcl <= HCL_OFF;
         avg_per <= AVG_RST;
         rec_sel <= '0;
      end else if (wr_en) begin
         case (paddr)
            A_CFG: begin
               ofs_en <= pwdata[CFG_OFSEN];
               if (type_ok) begin
                  mtype <= pwdata[3:0];
                  if (pwdata[3:0] != T_LIM) hcl <= HCL_OFF;
               end
            end
            A_OFS: begin
               if (ofs_en && $signed(pwdata) >= -OFS_LIM &&
                   $signed(pwdata) <= OFS_LIM) ofs <= pwdata[7:0];
            end
            A_HCL: begin
               if (mtype == T_LIM && pwdata[31:16] == 16'h0 &&
                   ((pwdata[15:0] >= HCL_MIN && pwdata[15:0] <= HCL_MAX) ||
                    pwdata[15:0] == HCL_OFF)) hcl <= pwdata[15:0];
            end
            A_AVG: begin
               if (pwdata[31:11] == 21'h0 && pwdata[10:0] >= AVG_MIN &&
                   pwdata[10:0] <= AVG_MAX) avg_per <= pwdata[10:0];
            end
            A_SEL: rec_sel <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // offset correction
   assign ofs_ext = ofs_en ? 16'(ofs) : 16'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corr_valid <= 1'b0;
         inlet_corr <= '0;
         outlet_corr <= '0;
         aux_corr <= '0;
         offset_off <= 1'b0;
      end else begin
         corr_valid <= temp_valid;
         offset_off <= !ofs_en;
         if (temp_valid) begin
            inlet_corr <= inlet_temp + ofs_ext;
            outlet_corr <= outlet_temp + ofs_ext;
            aux_corr <= aux_temp + ofs_ext;
         end
      end
   end

   // heat or cooling decision
   logic lim_on;
   logic hot_ok;
   logic heat_dec;
   logic cool_dec;
   assign lim_on = mtype == T_LIM && hcl != HCL_OFF;
   assign hot_ok = !lim_on || inlet_corr >= $signed({1'b0, hcl[14:0]});
   assign heat_dec = inlet_corr > outlet_corr && hot_ok &&
                     mtype != T_COOL;
   assign cool_dec = inlet_corr < outlet_corr && !(lim_on && hot_ok) &&
                     mtype != T_HEAT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heat_active <= 1'b0;
         cool_active <= 1'b0;
         heat_energy_acc <= '0;
         cooling_energy_acc <= '0;
      end else if (calc_strobe) begin
         heat_active <= heat_dec;
         cool_active <= cool_dec;
         if (heat_dec) heat_energy_acc <= heat_energy_acc + 32'(energy_incr);
         if (cool_dec) cooling_energy_acc <= cooling_energy_acc + 32'(energy_incr);
      end
   end

   // per-minute sums and sliding window
   logic [31:0] m_sum [2];
   logic [15:0] m_cnt;
   logic [31:0] ring_sum [2][WIN_MAX];
   logic [15:0] ring_cnt [WIN_MAX];
   logic [10:0] wp;
   logic [10:0] fill;
   logic [31:0] w_sum [2];
   logic [23:0] w_cnt;
   logic full;
   logic div_go;
   assign full = fill == avg_per;

   always_ff @(posedge pclk) begin
      if (minute_tick) begin
         ring_sum[0][wp] <= m_sum[0];
         ring_sum[1][wp] <= m_sum[1];
         ring_cnt[wp] <= m_cnt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_sum[0] <= '0;
         m_sum[1] <= '0;
         m_cnt <= '0;
      end else if (minute_tick) begin
         m_sum[0] <= sample_valid ? 32'(flow_val) : 32'h0;
         m_sum[1] <= sample_valid ? 32'(power_val) : 32'h0;
         m_cnt <= sample_valid ? 16'h1 : 16'h0;
      end else if (sample_valid) begin
         m_sum[0] <= m_sum[0] + 32'(flow_val);
         m_sum[1] <= m_sum[1] + 32'(power_val);
         m_cnt <= m_cnt + 16'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_q <= AVG_RST;
         wp <= '0;
         fill <= '0;
         w_sum[0] <= '0;
         w_sum[1] <= '0;
         w_cnt <= '0;
         div_go <= 1'b0;
      end else if (per_q != avg_per) begin
         per_q <= avg_per;
         wp <= '0;
         fill <= '0;
         w_sum[0] <= '0;
         w_sum[1] <= '0;
         w_cnt <= '0;
         div_go <= 1'b0;
      end else begin
         div_go <= minute_tick;
         if (minute_tick) begin
            // oldest minute drops out once window is full
            w_sum[0] <= w_sum[0] + m_sum[0] - (full ? ring_sum[0][wp] : 32'h0);
            w_sum[1] <= w_sum[1] + m_sum[1] - (full ? ring_sum[1][wp] : 32'h0);
            w_cnt <= w_cnt + 24'(m_cnt) - (full ? 24'(ring_cnt[wp]) : 24'h0);
            wp <= wp == avg_per - 11'h1 ? 11'h0 : wp + 11'h1;
            if (!full) fill <= fill + 11'h1;
         end
      end
   end

   // mean by serial division, flow then power
   mcc_state_t st;
   logic ch;
   logic [31:0] quo;
   logic [23:0] rem;
   logic [4:0] bitn;
   logic [VW-1:0] avg;
   logic [24:0] rs;
   logic ge;
   logic [24:0] rsub;
   assign rs = {rem, quo[31]};
   assign ge = rs >= {1'b0, w_cnt};
   assign rsub = rs - {1'b0, w_cnt};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_IDLE;
         ch <= 1'b0;
         quo <= '0;
         rem <= '0;
         bitn <= '0;
         avg <= '0;
      end else begin
         case (st)
            ST_IDLE: begin
               if (div_go && w_cnt != 24'h0) begin
                  st <= ST_DIV;
                  ch <= 1'b0;
                  quo <= w_sum[0];
                  rem <= '0;
                  bitn <= 5'h1f;
               end
            end
            ST_DIV: begin
               quo <= {quo[30:0], ge};
               rem <= ge ? rsub[23:0] : rs[23:0];
               bitn <= bitn - 5'h1;
               if (bitn == 5'h0) begin
                  st <= ST_CMP;
                  avg <= |quo[30:15] ? 16'hffff : {quo[14:0], ge};
               end
            end
            ST_CMP: begin
               if (!ch) begin
                  st <= ST_DIV;
                  ch <= 1'b1;
                  quo <= w_sum[1];
                  rem <= '0;
                  bitn <= 5'h1f;
               end else begin
                  st <= ST_IDLE;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // current records: index {quantity, year, max}
   logic [VW-1:0] cur_val [8];
   logic [DTW-1:0] cur_dt [8];
   logic [7:0] cur_ok;
   logic [VW-1:0] mlog_val [MLOG*4];
   logic [DTW-1:0] mlog_dt [MLOG*4];
   logic [VW-1:0] ylog_val [YLOG*4];
   logic [DTW-1:0] ylog_dt [YLOG*4];

   for (genvar i = 0; i < 8; i++) begin : g_cur
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cur_val[i] <= '0;
            cur_dt[i] <= '0;
            cur_ok[i] <= 1'b0;
         end else if ((i % 4 < 2) ? month_roll : year_roll) begin
            cur_ok[i] <= 1'b0;
         end else if (st == ST_CMP && ch == (i / 4 == 1) &&
                      (!cur_ok[i] || ((i % 2 == 1) ? avg > cur_val[i] :
                                      avg < cur_val[i]))) begin
            cur_val[i] <= avg;
            cur_dt[i] <= {rtc_date, rtc_time};
            cur_ok[i] <= 1'b1;
         end
      end
   end

   // history shift on month and year close
   for (genvar e = 0; e < MLOG * 4; e++) begin : g_mlog
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mlog_val[e] <= '0;
            mlog_dt[e] <= '0;
         end else if (month_roll) begin
            if (e < 4) begin
               mlog_val[e] <= cur_ok[(e/2)*4+e%2] ? cur_val[(e/2)*4+e%2] : '0;
               mlog_dt[e] <= cur_dt[(e/2)*4+e%2];
            end else begin
               mlog_val[e] <= mlog_val[(e<4) ? 0 : e-4];
               mlog_dt[e] <= mlog_dt[(e<4) ? 0 : e-4];
            end
         end
      end
   end

   for (genvar e = 0; e < YLOG * 4; e++) begin : g_ylog
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ylog_val[e] <= '0;
            ylog_dt[e] <= '0;
         end else if (year_roll) begin
            if (e < 4) begin
               ylog_val[e] <= cur_ok[(e/2)*4+2+e%2] ? cur_val[(e/2)*4+2+e%2] : '0;
               ylog_dt[e] <= cur_dt[(e/2)*4+2+e%2];
            end else begin
               ylog_val[e] <= ylog_val[(e<4) ? 0 : e-4];
               ylog_dt[e] <= ylog_dt[(e<4) ? 0 : e-4];
            end
         end
      end
   end

   // record readout
   logic [VW-1:0] r_val;
   logic [DTW-1:0] r_dt;
   int hx;
   always_comb begin
      r_val = '0;
      r_dt = '0;
      hx = int'(rec_sel[7:4]) * 4 + int'({rec_sel[SEL_QTY], rec_sel[SEL_MX]});
      if (!rec_sel[SEL_LOG]) begin
         r_val = cur_val[rec_sel[2:0]];
         r_dt = cur_dt[rec_sel[2:0]];
      end else if (rec_sel[SEL_YR]) begin
         if (hx < YLOG * 4) begin
            r_val = ylog_val[hx];
            r_dt = ylog_dt[hx];
         end
      end else if (hx < MLOG * 4) begin
         r_val = mlog_val[hx];
         r_dt = mlog_dt[hx];
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      case (paddr)
         A_CFG: rd_data = {27'h0, ofs_en, mtype};
         A_OFS: rd_data = ofs_en ? 32'(ofs) : OFF_READ;
         A_HCL: rd_data = {16'h0, hcl};
         A_AVG: rd_data = {21'h0, avg_per};
         A_HEAT: rd_data = heat_energy_acc;
         A_COOL: rd_data = cooling_energy_acc;
         A_SEL: rd_data = {24'h0, rec_sel};
         A_RVAL: rd_data = {16'h0, r_val};
         A_RDATE: rd_data = {CENTURY + 16'(r_dt[32:26]), 4'h0, r_dt[25:22],
                             3'h0, r_dt[21:17]};
         A_RTIME: rd_data = {15'h0, r_dt[16:0]};
         default: begin
            rd_data = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // display indicators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_min <= 1'b0;
         ind_max <= 1'b0;
         ind_log <= 1'b0;
         frame_year <= 1'b0;
         frame_month <= 1'b0;
      end else begin
         ind_max <= rec_sel[SEL_MX];
         ind_min <= !rec_sel[SEL_MX];
         ind_log <= rec_sel[SEL_LOG];
         frame_year <= rec_sel[SEL_YR];
         frame_month <= !rec_sel[SEL_YR];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OFS_RANGE: assert property ($signed(ofs) >= -8'sh63 && $signed(ofs) <= 8'sh63)
      else $error("offset out of range");
   AST_OFS_ADD: assert property (temp_valid |=> inlet_corr ==
                   16'($past(inlet_temp) + $past(ofs_ext)) && aux_corr ==
                   16'($past(aux_temp) + $past(ofs_ext)))
      else $error("offset not added");
   AST_OFS_OFF: assert property (temp_valid && !ofs_en |=> outlet_corr ==
                   $past(outlet_temp) && offset_off)
      else $error("disabled offset applied");
   AST_EQUAL: assert property (calc_strobe && inlet_corr == outlet_corr
                   |=> !heat_active && !cool_active)
      else $error("energy counted at equal temps");
   AST_BIF_HEAT: assert property (calc_strobe && mtype == T_BIF &&
                   inlet_corr > outlet_corr |=> heat_active && !cool_active)
      else $error("bifunctional heat missed");
   AST_LIM: assert property (calc_strobe && lim_on && inlet_corr <
                   $signed({1'b0, hcl[14:0]}) |=> !heat_active)
      else $error("heat below limit");
   AST_HCL_TYPE: assert property (mtype != T_LIM |-> hcl == HCL_OFF)
      else $error("limit active outside type 6");
   AST_PER: assert property (avg_per >= AVG_MIN && avg_per <= AVG_MAX)
      else $error("period out of range");
   AST_MAX_UP: assert property (cur_ok[1] && !month_roll |=>
                   cur_val[1] >= $past(cur_val[1]))
      else $error("monthly max fell");
   AST_DIV_LEN: assert property ($rose(st == ST_DIV) |-> ##32 st == ST_CMP)
      else $error("division length wrong");

   COV_HEAT: cover property (calc_strobe && heat_dec);
   COV_COOL: cover property (calc_strobe && cool_dec);
   COV_REC: cover property (st == ST_CMP && ch);
   COV_ROLL: cover property (month_roll && cur_ok[0]);
endmodule : mcc_calc
`default_nettype wire

// *** bench/mcc_calc_tb.sv ***
// testbench: bus, offset, heat/cooling and min/max record scenarios
`timescale 1ns/1ps
`default_nettype none
module mcc_calc_tb;
   import mcc_pkg::*;
   localparam int LIMIT = 8000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, heat_energy_acc, cooling_energy_acc, rd_v, h_exp, c_exp;
   logic temp_valid, corr_valid, calc_strobe, heat_active, cool_active, err_v;
   logic signed [TW-1:0] inlet_temp, outlet_temp, aux_temp, inlet_corr, outlet_corr, aux_corr;
   logic [15:0] energy_incr, rtc_date;
   logic sample_valid, minute_tick, month_roll, year_roll;
   logic [VW-1:0] flow_val, power_val;
   logic [16:0] rtc_time;
   logic offset_off, ind_min, ind_max, ind_log, frame_year, frame_month;
   int fails, samples_checked, cyc;

   mcc_calc mcc_calc_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .temp_valid(temp_valid), .inlet_temp(inlet_temp), .outlet_temp(outlet_temp),
      .aux_temp(aux_temp), .corr_valid(corr_valid), .inlet_corr(inlet_corr),
      .outlet_corr(outlet_corr), .aux_corr(aux_corr), .calc_strobe(calc_strobe),
      .energy_incr(energy_incr), .heat_active(heat_active), .cool_active(cool_active),
      .heat_energy_acc(heat_energy_acc), .cooling_energy_acc(cooling_energy_acc),
      .sample_valid(sample_valid), .flow_val(flow_val), .power_val(power_val),
      .minute_tick(minute_tick), .month_roll(month_roll), .year_roll(year_roll),
      .rtc_date(rtc_date), .rtc_time(rtc_time), .offset_off(offset_off), .ind_min(ind_min),
      .ind_max(ind_max), .ind_log(ind_log), .frame_year(frame_year), .frame_month(frame_month)
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] val, input logic [31:0] exp);
      samples_checked++;
      if (val !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, val, exp);
      end
   endtask : check

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd_v, exp);
   endtask : rd

   task automatic pulse_temps(input int tin, input int tout, input int taux);
      @(posedge pclk);
      temp_valid <= 1'b1;
      inlet_temp <= 16'(tin);
      outlet_temp <= 16'(tout);
      aux_temp <= 16'(taux);
      @(posedge pclk);
      temp_valid <= 1'b0;
      #1;
   endtask : pulse_temps

   // corrected temps must be raw plus the offset, for all three sensors
   task automatic tcorr(input int o);
      pulse_temps(2000, 1500, -300);
      check(32'(corr_valid), 32'h1);
      check(32'(inlet_corr), 32'(16'(2000 + o)));
      check(32'(outlet_corr), 32'(16'(1500 + o)));
      check(32'(aux_corr), 32'(16'(-300 + o)));
   endtask : tcorr

   task automatic hc(input int tin, input int tout, input logic h, input logic c);
      pulse_temps(tin, tout, 0);
      @(posedge pclk);
      calc_strobe <= 1'b1;
      energy_incr <= 16'h0011;
      @(posedge pclk);
      calc_strobe <= 1'b0;
      #1;
      if (h) h_exp += 32'h11;
      if (c) c_exp += 32'h11;
      check(32'(heat_active), 32'(h));
      check(32'(cool_active), 32'(c));
      check(heat_energy_acc, h_exp);
      check(cooling_energy_acc, c_exp);
   endtask : hc

   task automatic samp(input logic [15:0] f);
      @(posedge pclk);
      sample_valid <= 1'b1;
      flow_val <= f;
      power_val <= f * 16'h000a;
      @(posedge pclk);
      sample_valid <= 1'b0;
   endtask : samp

   task automatic tick(input logic [2:0] kind);
      @(posedge pclk);
      minute_tick <= kind[0];
      month_roll <= kind[1];
      year_roll <= kind[2];
      @(posedge pclk);
      minute_tick <= 1'b0;
      month_roll <= 1'b0;
      year_roll <= 1'b0;
      repeat (80) @(posedge pclk);
   endtask : tick

   // select a record, read its value and the indicator levels
   task automatic rec(input logic [7:0] s, input logic [31:0] exp);
      apb(1'b1, A_SEL, {24'h0, s});
      rd(A_RVAL, exp);
      check({ind_min, ind_max, ind_log}, {!s[0], s[0], s[3]});
      check({frame_year, frame_month}, {s[1], !s[1]});
   endtask : rec

   initial begin
      {presetn, psel, penable, pwrite, temp_valid, calc_strobe, sample_valid} = '0;
      {minute_tick, month_roll, year_roll, fails, samples_checked, cyc} = '0;
      {paddr, pwdata, inlet_temp, outlet_temp, aux_temp, energy_incr} = '0;
      {flow_val, power_val, rtc_time, h_exp, c_exp} = '0;
      rtc_date = {7'd24, 4'd3, 5'd7};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CFG, 32'h12);
      rd(A_OFS, 32'h0);
      rd(A_HCL, 32'h61a8);
      rd(A_AVG, 32'h3c);
      rd(8'h40, 32'h0);
      check(32'(err_v), 32'h1);
      check(32'(offset_off), 32'h0);
      $display("test reset values done");
      tcorr(0);
      apb(1'b1, A_OFS, 32'h63);
      tcorr(99);
      apb(1'b1, A_OFS, 32'hffffff9d);
      apb(1'b1, A_OFS, 32'h64);
      tcorr(-99);
      apb(1'b1, A_CFG, 32'h02);
      rd(A_OFS, OFF_READ);
      check(32'(offset_off), 32'h1);
      tcorr(0);
      $display("test offset done");
      hc(2500, 2000, 1, 0);
      hc(2000, 2500, 0, 0);
      apb(1'b1, A_CFG, 32'h05);
      hc(2000, 2500, 0, 1);
      hc(2500, 2000, 0, 0);
      apb(1'b1, A_CFG, 32'h03);
      hc(2500, 2000, 1, 0);
      hc(2000, 2500, 0, 1);
      hc(2200, 2200, 0, 0);
      apb(1'b1, A_HCL, 32'h7d0);
      rd(A_HCL, 32'h61a8);
      apb(1'b1, A_CFG, 32'h06);
      apb(1'b1, A_HCL, 32'h4651);
      rd(A_HCL, 32'h61a8);
      apb(1'b1, A_HCL, 32'h7d0);
      rd(A_HCL, 32'h7d0);
      hc(2500, 2000, 1, 0);
      hc(1900, 1500, 0, 0);
      hc(1500, 1800, 0, 1);
      hc(2100, 2200, 0, 0);
      hc(2000, 1000, 1, 0);
      apb(1'b1, A_HCL, 32'h61a8);
      hc(2100, 2200, 0, 1);
      rd(A_HEAT, h_exp);
      apb(1'b1, A_CFG, 32'h03);
      rd(A_HCL, 32'h61a8);
      $display("test heat cooling done");
      apb(1'b1, A_AVG, 32'h5a1);
      rd(A_AVG, 32'h3c);
      apb(1'b1, A_AVG, 32'h1);
      rd(A_AVG, 32'h1);
      samp(16'd10);
      samp(16'd20);
      tick(3'b001);
      rec(8'h00, 32'd15);
      rec(8'h01, 32'd15);
      rec(8'h05, 32'd150);
      rec(8'h03, 32'd15);
      rtc_date <= {7'd24, 4'd3, 5'd9};
      rtc_time <= {5'd13, 6'd45, 6'd30};
      samp(16'd30);
      tick(3'b001);
      rec(8'h01, 32'd30);
      rd(A_RDATE, {16'd2024, 4'h0, 4'd3, 3'h0, 5'd9});
      rd(A_RTIME, {15'h0, 5'd13, 6'd45, 6'd30});
      rec(8'h00, 32'd15);
      rd(A_RDATE, {16'd2024, 4'h0, 4'd3, 3'h0, 5'd7});
      samp(16'd5);
      tick(3'b001);
      rec(8'h00, 32'd5);
      tick(3'b110);
      rec(8'h09, 32'd30);
      rec(8'h0b, 32'd30);
      rec(8'h0e, 32'd50);
      $display("test min max done");
      wrap_up();
   end
endmodule : mcc_calc_tb
`default_nettype wire
